// >>> src/pgt_map.vh
// constants for the pause gate timing block
`ifndef PGT_MAP_VH
`define PGT_MAP_VH
`define PGT_CH_W        5
`define PGT_NUM_CH_3    5'h10
`define PGT_NUM_CH_5    5'h14
`define PGT_CONV_W      3
`define PGT_CONV_FIRST  3'h0
`define PGT_CONV_SECOND 3'h1
`define PGT_CONV_THIRD  3'h2
`define PGT_NUM_CONV5   3'h5
`define PGT_CNT_W       32
`define PGT_CNT_RST     32'h00000000
`define PGT_PER_W       16
`define PGT_PER_RST     16'h0001
`endif

// >>> src/pgt_pause_gate.v
// pause gating for sample timing, pulse train and edge counter
`timescale 1ns/10ps
`default_nettype none
`include "pgt_map.vh"

module pgt_pause_gate #(
  parameter CH_W   = `PGT_CH_W,
  parameter CNT_W  = `PGT_CNT_W,
  parameter PER_W  = `PGT_PER_W
) (
  input  wire             mclk,          // 125 MHz clock
  input  wire             rst,           // sync reset, active high
  input  wire             clk_en,        // freezes all state when low
  input  wire             pause_in,      // pause pin, async
  input  wire             samp_clk_in,   // external sample clock pin, async
  input  wire             use_ext_clk,   // 1: external sample clock source
  input  wire             int_tick,      // internal timebase sample tick
  input  wire             five_conv,     // 1: five-converter mode
  input  wire [CH_W-1:0]  scan_last,     // last channel index of scan
  input  wire             cjc_chan,      // current scan entry is junction ch
  input  wire             ctr_src_in,    // edge counter source pin, async
  input  wire             pulse_en,      // pulse train enable
  input  wire [PER_W-1:0] high_ticks,    // pulse high length
  input  wire [PER_W-1:0] low_ticks,     // pulse low length
  output reg              paused_q,      // sample timing is paused
  output reg              conv_strobe_q, // one-cycle conversion start
  output reg  [CH_W-1:0]  chan_q,        // channel of conversion
  output reg  [2:0]       conv_sel_q,    // converter serving chan_q
  output reg  [CNT_W-1:0] samp_cnt_q,    // completed scans
  output reg              pulse_out_q,   // pulse train output
  output reg  [CNT_W-1:0] edge_cnt_q     // counted source edges
);

  // ----------------------------------------------------------------
  // converter select
  // ----------------------------------------------------------------
  function [2:0] conv_of;
    input [CH_W-1:0] ch;
    input            five;
    input            cjc;
    reg   [CH_W-1:0] rem;
    begin
      rem = ch % `PGT_NUM_CONV5;
      if (five)
        conv_of = rem[2:0];
      else if (cjc)
        conv_of = `PGT_CONV_THIRD;
      else if (ch[0])
        conv_of = `PGT_CONV_SECOND;
      else
        conv_of = `PGT_CONV_FIRST;
    end
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // only the second flop of each chain is read; the edge detectors
  // reset low, the idle level of every pin, so no false edge follows
  localparam N_SYNC = 3;

  wire [N_SYNC-1:0] pin_w = {ctr_src_in, samp_clk_in, pause_in};
  wire [N_SYNC-1:0] pin_s;
  wire [N_SYNC-1:0] pin_d1;

  genvar gi;
  generate
    for (gi = 0; gi < N_SYNC; gi = gi + 1)
    begin : g_sync
      reg [1:0] sync_q;
      reg       last_q;

      always @(posedge mclk)
      begin
        if (rst)
        begin
          sync_q <= 2'h0;
          last_q <= 1'b0;
        end
        else if (clk_en)
        begin
          sync_q <= {sync_q[0], pin_w[gi]};
          last_q <= sync_q[1];
        end
      end

      assign pin_s[gi]  = sync_q[1];
      assign pin_d1[gi] = last_q;
    end
  endgenerate

  wire pause_w   = pin_s[0];
  wire ext_edge  = pin_s[1] & ~pin_d1[1];
  wire src_edge  = pin_s[2] & ~pin_d1[2];
  wire samp_tick = use_ext_clk ? ext_edge : int_tick;

  // ----------------------------------------------------------------
  // sample timing state machine
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 2'h0;
  localparam ST_SCAN  = 2'h1;
  localparam ST_PAUSE = 2'h2;
  localparam ST_ARM   = 2'h3;

  reg [1:0]      st_q;
  reg [1:0]      st_d;
  reg [CH_W-1:0] ch_q;
  reg            scan_go;
  reg            five_q;

  // mode is taken as a scan starts, so one scan never mixes two maps
  always @(posedge mclk)
  begin
    if (rst)
      five_q <= 1'b0;
    else if (clk_en && (st_q != ST_SCAN))
      five_q <= five_conv;
  end

  // ----------------------------------------------------------------
  // scan length
  // ----------------------------------------------------------------
  // a last index past the mode's channel count is cut back, so a bad
  // setting cannot run the scan onto channels that do not exist
  function [CH_W-1:0] last_of;
    input [CH_W-1:0] want;
    input            five;
    reg   [CH_W-1:0] lim;
    begin
      if (five)
        lim = `PGT_NUM_CH_5 - 5'h01;
      else
        lim = `PGT_NUM_CH_3 - 5'h01;
      if (want > lim)
        last_of = lim;
      else
        last_of = want;
    end
  endfunction

  wire [CH_W-1:0] last_ch  = last_of(scan_last, five_q);
  wire            scan_end = (ch_q == last_ch);

  // idle waits for a tick; pause is only honoured between scans,
  // and the release path depends on the sample clock source

  always @*
  begin
    st_d    = st_q;
    scan_go = 1'b0;
    case (st_q)
      ST_IDLE:
      begin
        if (pause_w)
          st_d = ST_PAUSE;
        else if (samp_tick)
          st_d = ST_SCAN;
      end
      ST_SCAN:
      begin
        // scan runs to its end even if pause arrived mid-way
        scan_go = 1'b1;
        if (scan_end)
          st_d = pause_w ? ST_PAUSE : ST_IDLE;
      end
      ST_PAUSE:
      begin
        if (!pause_w)
          st_d = use_ext_clk ? ST_ARM : ST_IDLE;
      end
      ST_ARM:
      begin
        // external source waits for a fresh edge after release; a
        // switch back to the internal timebase resumes at once
        if (pause_w)
          st_d = ST_PAUSE;
        else if (!use_ext_clk)
          st_d = ST_IDLE;
        else if (ext_edge)
          st_d = ST_SCAN;
      end
      default:
        st_d = ST_IDLE;
    endcase
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      st_q          <= ST_IDLE;
      paused_q      <= 1'b0;
      conv_strobe_q <= 1'b0;
    end
    else if (clk_en)
    begin
      st_q          <= st_d;
      paused_q      <= (st_d == ST_PAUSE) | (st_d == ST_ARM);
      conv_strobe_q <= scan_go;
    end
  end

  // ----------------------------------------------------------------
  // scan position and completed-scan count
  // ----------------------------------------------------------------
  // position moves only with a strobe, so a pause leaves it parked
  always @(posedge mclk)
  begin
    if (rst)
    begin
      ch_q       <= {CH_W{1'b0}};
      chan_q     <= {CH_W{1'b0}};
      conv_sel_q <= `PGT_CONV_FIRST;
      samp_cnt_q <= `PGT_CNT_RST;
    end
    else if (clk_en && scan_go)
    begin
      chan_q     <= ch_q;
      conv_sel_q <= conv_of(ch_q, five_q, cjc_chan);
      ch_q       <= scan_end ? {CH_W{1'b0}} : ch_q + 1'b1;
      if (scan_end)
        samp_cnt_q <= samp_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pulse train
  // ----------------------------------------------------------------
  reg [PER_W-1:0] ph_cnt_q;
  reg [PER_W-1:0] ph_cnt_d;
  reg             pulse_d;

  wire [PER_W-1:0] ph_len  = pulse_out_q ? high_ticks : low_ticks;
  wire             ph_done = (ph_cnt_q >= ph_len);

  // frozen mid-phase keeps level and count, so that phase is stretched
  // by exactly the pause; a disabled train parks low and restarts clean
  always @*
  begin
    ph_cnt_d = ph_cnt_q;
    pulse_d  = pulse_out_q;
    if (!pulse_en)
    begin
      ph_cnt_d = `PGT_PER_RST;
      pulse_d  = 1'b0;
    end
    else if (!pause_w)
    begin
      if (ph_done)
      begin
        ph_cnt_d = `PGT_PER_RST;
        pulse_d  = ~pulse_out_q;
      end
      else
        ph_cnt_d = ph_cnt_q + 1'b1;
    end
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      ph_cnt_q    <= `PGT_PER_RST;
      pulse_out_q <= 1'b0;
    end
    else if (clk_en)
    begin
      ph_cnt_q    <= ph_cnt_d;
      pulse_out_q <= pulse_d;
    end
  end

  // ----------------------------------------------------------------
  // edge counter
  // ----------------------------------------------------------------
  always @(posedge mclk)
  begin
    if (rst)
      edge_cnt_q <= `PGT_CNT_RST;
    else if (clk_en)
    begin
      // an edge that lands while paused is dropped, not deferred
      if (src_edge && !pause_w)
        edge_cnt_q <= edge_cnt_q + 1'b1;
    end
  end

endmodule // pgt_pause_gate

`default_nettype wire

// >>> dv/pgt_pause_src.sv
// far-side pause trigger and external sample clock source
`timescale 1ns/10ps
`default_nettype none
module pgt_pause_src (
  input  wire logic mclk,        // bench clock
  input  wire logic hold,        // pause wanted
  input  wire logic go,          // run sample clock
  output var  logic pause_in,    // pause pin
  output var  logic samp_clk_in  // sample clock pin
);
  logic [2:0] n_q = 3'h0;
  initial pause_in = 1'b0;
  initial samp_clk_in = 1'b0;
  // lands mid-cycle, unrelated to the sampling edge
  always @(posedge mclk) pause_in <= #3 hold;
  // clock stands low outside frames
  always @(posedge mclk)
  begin
    n_q <= (n_q == 3'h5) ? 3'h0 : n_q + 3'h1;
    samp_clk_in <= #3 go && (n_q < 3'h3);
  end
endmodule // pgt_pause_src
`default_nettype wire

// >>> dv/pgt_pause_gate_chk.sv
// port-level checker for the pause gate
`timescale 1ns/10ps
`default_nettype none
module pgt_pause_gate_chk (
  input wire logic mclk, rst, pause_in, samp_clk_in, use_ext_clk,
  input wire logic five_conv, paused_q, conv_strobe_q, pulse_out_q,
  input wire logic [4:0] scan_last, chan_q,
  input wire logic [2:0] conv_sel_q,
  input wire logic [31:0] samp_cnt_q, edge_cnt_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_stop_paused: assert property (paused_q && !use_ext_clk |=>
    !conv_strobe_q) else $error("strobe while paused");
  a_pause_cause: assert property ($rose(paused_q) |->
    $past(pause_in, 3)) else $error("pause without pin");
  a_resume_int: assert property ((!use_ext_clk && !pause_in)[*4]
    |-> !paused_q) else $error("late resume");
  a_resume_ext: assert property ((use_ext_clk && paused_q &&
    !samp_clk_in)[*4] |=> paused_q) else $error("resume with no edge");
  a_pulse_hold: assert property (pause_in[*5] |=>
    $stable(pulse_out_q)) else $error("pulse moved in pause");
  a_edge_hold: assert property (pause_in[*5] |=>
    $stable(edge_cnt_q)) else $error("edge counted in pause");
  a_map_three: assert property (conv_strobe_q && !five_conv &&
    conv_sel_q != 3'h2 |-> conv_sel_q == {2'h0, chan_q[0]})
    else $error("bad three-way map");
  a_scan_order: assert property (conv_strobe_q && chan_q !=
    scan_last |=> conv_strobe_q && chan_q == $past(chan_q) + 5'h1)
    else $error("scan broken");
  a_map_five: assert property (conv_strobe_q && five_conv |->
    conv_sel_q == 3'(chan_q % 5)) else $error("bad five-way map");
  a_count_step: assert property ($changed(samp_cnt_q) |->
    samp_cnt_q == $past(samp_cnt_q) + 32'h1 &&
    (conv_strobe_q || $past(conv_strobe_q))) else $error("bad count");
endmodule // pgt_pause_gate_chk
bind pgt_pause_gate pgt_pause_gate_chk u_chk (.*);
`default_nettype wire

// >>> dv/pgt_pause_gate_tb_top.sv
// self-checking bench for the pause gate
`timescale 1ns/10ps
`default_nettype none
module pgt_pause_gate_tb_top;
  logic mclk = 0, rst = 1, clk_en = 1, int_tick = 0, use_ext_clk = 0;
  logic five_conv = 0, cjc_chan = 0, ctr_src_in = 0, pulse_en = 0;
  logic hold = 0, go = 0, s, p, pause_in, samp_clk_in;
  logic paused_q, conv_strobe_q, pulse_out_q;
  logic [4:0] scan_last = 5'h3, chan_q;
  logic [2:0] conv_sel_q;
  logic [15:0] high_ticks = 16'h3, low_ticks = 16'h5;
  logic [31:0] samp_cnt_q, edge_cnt_q, lfsr = 32'h6f75, c;
  int n_mismatch = 0, tests_run = 0, i, t;
  always #4 mclk = ~mclk;
  pgt_pause_gate uut (.mclk(mclk), .rst(rst), .clk_en(clk_en),
    .pause_in(pause_in), .samp_clk_in(samp_clk_in),
    .use_ext_clk(use_ext_clk), .int_tick(int_tick),
    .five_conv(five_conv), .scan_last(scan_last), .cjc_chan(cjc_chan),
    .ctr_src_in(ctr_src_in), .pulse_en(pulse_en),
    .high_ticks(high_ticks), .low_ticks(low_ticks),
    .paused_q(paused_q), .conv_strobe_q(conv_strobe_q),
    .chan_q(chan_q), .conv_sel_q(conv_sel_q), .samp_cnt_q(samp_cnt_q),
    .pulse_out_q(pulse_out_q), .edge_cnt_q(edge_cnt_q));
  pgt_pause_src u_src (.mclk(mclk), .hold(hold), .go(go),
    .pause_in(pause_in), .samp_clk_in(samp_clk_in));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) $display("ERROR %0t seen %h exp %h", $time, seen,
      exp);
    if (seen !== exp) n_mismatch++;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one tick, then every strobe of the scan is checked in turn
  task automatic scan(input logic f, input logic j);
    @(posedge mclk);
    five_conv <= f;
    cjc_chan <= j;
    scan_last <= 5'(rnd() % (f ? 20 : 16));
    int_tick <= 1;
    @(posedge mclk);
    int_tick <= 0;
    #1;
    c = samp_cnt_q;
    for (i = 0; i < 9 && conv_strobe_q !== 1'b1; i++) cyc(1);
    for (i = 0; i <= scan_last; i++)
    begin
      chk(chan_q, i);
      chk(conv_sel_q, f ? i % 5 : (j ? 2 : i % 2));
      cyc(1);
    end
    chk(samp_cnt_q, c + 1);
  endtask
  initial begin
    cyc(4);
    rst <= 0;
    for (t = 0; t < 6; t++) scan(t[0], t[1]);
    $display("scan test done");
    hold <= 1;
    cyc(6);
    c = samp_cnt_q;
    int_tick <= 1;
    cyc(1);
    int_tick <= 0;
    s = 0;
    for (i = 0; i < 8; i++) begin cyc(1); s |= conv_strobe_q; end
    chk(s, 0);
    hold <= 0;
    cyc(5);
    chk(paused_q, 0);
    chk(samp_cnt_q, c);
    use_ext_clk <= 1;
    hold <= 1;
    cyc(6);
    hold <= 0;
    cyc(10);
    chk(paused_q, 1);
    go <= 1;
    cyc(12);
    chk(paused_q, 0);
    go <= 0;
    cyc(24);
    hold <= 1;
    cyc(6);
    hold <= 0;
    cyc(8);
    chk(paused_q, 1);
    use_ext_clk <= 0;
    cyc(3);
    chk(paused_q, 0);
    cyc(30);
    $display("resume test done");
    hold <= 1;
    cyc(6);
    c = edge_cnt_q;
    repeat (8) begin ctr_src_in <= ~ctr_src_in; cyc(3); end
    chk(edge_cnt_q, c);
    hold <= 0;
    cyc(6);
    c = edge_cnt_q;
    repeat (6) begin ctr_src_in <= ~ctr_src_in; cyc(3); end
    cyc(4);
    chk(edge_cnt_q, c + 3);
    high_ticks <= 16'(rnd() % 6 + 1);
    low_ticks <= 16'(rnd() % 6 + 1);
    pulse_en <= 1;
    cyc(rnd() % 20 + 8);
    hold <= 1;
    cyc(5);
    p = pulse_out_q;
    cyc(20);
    chk(pulse_out_q, p);
    hold <= 0;
    s = 0;
    for (i = 0; i < 20; i++) begin cyc(1); s |= (pulse_out_q != p); end
    chk(s, 1);
    $display("counter test done");
    give_verdict;
  end
  initial begin
    cyc(4000);
    n_mismatch++;
    give_verdict;
  end
endmodule // pgt_pause_gate_tb_top
`default_nettype wire
